/* File: verilog/tcs_sequencer.sv */
// touch detect and x/y conversion sequencer with avalon registers
`timescale 1ns/100ps
// Function
// - interrupt clears on any register read, power-down write or a one written to its status bit
// - writing control zero then setting leaves no interrupt unless a conversion already under way completes
// - idle: y plate driven high, x plate driven low to sense touch
// - x plate pulled high starts conversion only if periodic enabled
// - touch not re-examined until both x and y samples taken
// - contact loss seen only after conversion, point reported normally
// - wait at least 1 ms after interrupt before next conversion
// - touch_async: touch low, interrupt high, both registered so the clock must run
// - 12-bit x and y, repeated at rate from control and rate regs
// - ratiometric: full plate voltage is code 4095
// - two interrupt causes: touch change and conversion done
// - event coinciding with a read keeps interrupt asserted
// - reset clears result and control regs, rate loads 32, mask loads 3
// - control all zero is power-down, periodic conversions stopped
module tcs_sequencer #(
  parameter int SETTLE_CYC = tcs_pkg::SETTLE_CYC,
  parameter int RATE_UNIT_CYC = tcs_pkg::RATE_UNIT_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic x_plate_high_i,
  output logic x_plate_high_o,
  output logic x_plate_high_oe,
  output logic x_plate_low_o,
  output logic x_plate_low_oe,
  input wire logic [11:0] y_plate_high_i,
  output logic y_plate_high_o,
  output logic y_plate_high_oe,
  output logic y_plate_low_o,
  output logic y_plate_low_oe,
  input wire logic [11:0] x_plate_sense,
  input wire logic [11:0] plate_span,
  input wire logic touch_async,
  output logic touch_n,
  output logic irq
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  tcs_adc_if adc();
  tcs_pkg::tcs_state_e state_q;
  logic [7:0] ctrl_q;
  logic [7:0] rate_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [11:0] x_q;
  logic [11:0] y_q;
  logic [11:0] x_tmp_q;
  logic [31:0] timer_q;
  logic touched_q;
  logic touch_async_q;
  logic ack_q;
  logic start_q;
  logic rd_take;
  logic wr_take;
  logic ev_touch;
  logic ev_conv;
  logic pd_write;
  logic [11:0] sense_mux;
  logic [31:0] gap_cyc;

  assign rd_take = avs_read && !ack_q;
  assign wr_take = avs_write && !ack_q;
  assign pd_write = wr_take && avs_byteenable[0] &&
    avs_address == tcs_pkg::ADDR_CTRL &&
    avs_writedata[7:0] == tcs_pkg::CTRL_POWER_DOWN;
  assign gap_cyc = {24'h00_0000, rate_q} * 32'(RATE_UNIT_CYC);
  // the undriven plate carries the reading: y during x, x during y
  assign sense_mux = (state_q == tcs_pkg::TCS_CONV_X) ? y_plate_high_i
    : x_plate_sense;
  assign adc.start = start_q;

  tcs_sample_conv #(.CYC(tcs_pkg::SAMPLE_CYC)) u_conv (
    .clk(clk),
    .rstn(rstn),
    .sense(sense_mux),
    .plate_span(plate_span),
    .adc(adc)
  );

  // ****************************************************************
  // avalon slave: one wait cycle, ack on the second
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_take) begin
      unique case (avs_address)
        tcs_pkg::ADDR_X_LO: avs_readdata <= {24'h00_0000, x_q[7:0]};
        tcs_pkg::ADDR_X_HI: avs_readdata <= {28'h000_0000, x_q[11:8]};
        tcs_pkg::ADDR_Y_LO: avs_readdata <= {24'h00_0000, y_q[7:0]};
        tcs_pkg::ADDR_Y_HI: avs_readdata <= {28'h000_0000, y_q[11:8]};
        tcs_pkg::ADDR_STAT: avs_readdata <= {24'h00_0000, touched_q,
          5'h00, stat_q};
        tcs_pkg::ADDR_MASK: avs_readdata <= {30'h0000_0000, mask_q};
        tcs_pkg::ADDR_CTRL: avs_readdata <= {24'h00_0000, ctrl_q};
        tcs_pkg::ADDR_RATE: avs_readdata <= {24'h00_0000, rate_q};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= tcs_pkg::CTRL_RESET;
      rate_q <= tcs_pkg::RATE_RESET;
      mask_q <= tcs_pkg::MASK_RESET;
    end else if (wr_take && avs_byteenable[0]) begin
      if (avs_address == tcs_pkg::ADDR_CTRL) ctrl_q <= avs_writedata[7:0];
      if (avs_address == tcs_pkg::ADDR_RATE) rate_q <= avs_writedata[7:0];
      if (avs_address == tcs_pkg::ADDR_MASK) mask_q <= avs_writedata[1:0];
    end
  end

  // ****************************************************************
  // interrupt status
  // ****************************************************************
  // any read clears all causes; a same-cycle event still sets
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == tcs_pkg::STAT_TOUCH_BIT && ev_touch) ||
            (i == tcs_pkg::STAT_CONV_BIT && ev_conv)) begin
          stat_q[i] <= 1'b1;
        end else if (rd_take || pd_write) begin
          stat_q[i] <= 1'b0;
        end else if (wr_take && avs_address == tcs_pkg::ADDR_STAT &&
                     avs_byteenable[0] && avs_writedata[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end

  // ****************************************************************
  // touch sensing and events
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      touch_n <= 1'b1;
    end else begin
      // the touch_async path is registered here, so it needs a running clock
      touch_n <= !(touched_q || touch_async);
    end
  end

  // reset low matches the idle pin level, so no false edge after reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      touch_async_q <= 1'b0;
    end else begin
      touch_async_q <= touch_async;
    end
  end

  always_comb begin
    ev_touch = 1'b0;
    ev_conv = 1'b0;
    if (ctrl_q[tcs_pkg::CTRL_TOUCH_IRQ_BIT] &&
        (state_q == tcs_pkg::TCS_IDLE || state_q == tcs_pkg::TCS_GAP) &&
        x_plate_high_i != touched_q) begin
      ev_touch = 1'b1;
    end
    // an edge only, so a held level does not re-raise after each read
    if (touch_async && !touch_async_q) begin
      ev_touch = 1'b1;
    end
    if (ctrl_q[tcs_pkg::CTRL_CONV_IRQ_BIT] &&
        state_q == tcs_pkg::TCS_CONV_Y && adc.done) begin
      ev_conv = 1'b1;
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= tcs_pkg::TCS_IDLE;
      timer_q <= 32'h0000_0000;
      touched_q <= 1'b0;
      start_q <= 1'b0;
      x_tmp_q <= 12'h000;
      x_q <= 12'h000;
      y_q <= 12'h000;
    end else begin
      start_q <= 1'b0;
      unique case (state_q)
        tcs_pkg::TCS_IDLE: begin
          touched_q <= x_plate_high_i;
          if (x_plate_high_i && ctrl_q[tcs_pkg::CTRL_PERIODIC_BIT] &&
              ctrl_q != tcs_pkg::CTRL_POWER_DOWN) begin
            state_q <= tcs_pkg::TCS_SETTLE;
            timer_q <= 32'h0000_0000;
          end
        end
        tcs_pkg::TCS_SETTLE: begin
          if (timer_q >= 32'(SETTLE_CYC - 1)) begin
            state_q <= tcs_pkg::TCS_CONV_X;
            start_q <= 1'b1;
          end else begin
            timer_q <= timer_q + 32'h0000_0001;
          end
        end
        tcs_pkg::TCS_CONV_X: begin
          if (adc.done) begin
            x_tmp_q <= adc.code;
            state_q <= tcs_pkg::TCS_CONV_Y;
            start_q <= 1'b1;
          end
        end
        tcs_pkg::TCS_CONV_Y: begin
          if (adc.done) begin
            x_q <= x_tmp_q;
            y_q <= adc.code;
            state_q <= tcs_pkg::TCS_GAP;
            timer_q <= 32'h0000_0000;
          end
        end
        tcs_pkg::TCS_GAP: begin
          touched_q <= x_plate_high_i;
          timer_q <= timer_q + 32'h0000_0001;
          if (!x_plate_high_i || ctrl_q == tcs_pkg::CTRL_POWER_DOWN ||
              !ctrl_q[tcs_pkg::CTRL_PERIODIC_BIT]) begin
            state_q <= tcs_pkg::TCS_IDLE;
          end else if (timer_q >= gap_cyc &&
                       timer_q >= 32'(SETTLE_CYC - 1)) begin
            state_q <= tcs_pkg::TCS_CONV_X;
            start_q <= 1'b1;
          end
        end
        default: state_q <= tcs_pkg::TCS_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // plate drive
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      x_plate_high_o <= 1'b0;
      x_plate_high_oe <= 1'b0;
      x_plate_low_o <= 1'b0;
      x_plate_low_oe <= 1'b1;
      y_plate_high_o <= 1'b1;
      y_plate_high_oe <= 1'b1;
      y_plate_low_o <= 1'b0;
      y_plate_low_oe <= 1'b0;
    end else begin
      // conv_x drives the x plate, y sense is the other plate
      if (state_q == tcs_pkg::TCS_CONV_X) begin
        x_plate_high_o <= 1'b1;
        x_plate_high_oe <= 1'b1;
        x_plate_low_o <= 1'b0;
        x_plate_low_oe <= 1'b1;
        y_plate_high_oe <= 1'b0;
        y_plate_low_oe <= 1'b0;
      end else if (state_q == tcs_pkg::TCS_CONV_Y) begin
        x_plate_high_oe <= 1'b0;
        x_plate_low_oe <= 1'b0;
        y_plate_high_o <= 1'b1;
        y_plate_high_oe <= 1'b1;
        y_plate_low_o <= 1'b0;
        y_plate_low_oe <= 1'b1;
      end else begin
        x_plate_high_oe <= 1'b0;
        x_plate_low_o <= 1'b0;
        x_plate_low_oe <= 1'b1;
        y_plate_high_o <= 1'b1;
        y_plate_high_oe <= 1'b1;
        y_plate_low_oe <= 1'b0;
      end
    end
  end
endmodule // tcs_sequencer

/* File: shared/tcs_pkg.sv */
// package of constants and types for the touch conversion sequencer
package tcs_pkg;
  // ****************************************************************
  // register byte addresses on the avalon bus (index * 4)
  // ****************************************************************
  localparam logic [4:0] ADDR_X_LO = 5'h00;
  localparam logic [4:0] ADDR_X_HI = 5'h04;
  localparam logic [4:0] ADDR_Y_LO = 5'h08;
  localparam logic [4:0] ADDR_Y_HI = 5'h0C;
  localparam logic [4:0] ADDR_STAT = 5'h10;
  localparam logic [4:0] ADDR_MASK = 5'h14;
  localparam logic [4:0] ADDR_CTRL = 5'h18;
  localparam logic [4:0] ADDR_RATE = 5'h1C;
  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CTRL_PERIODIC_BIT = 0;
  localparam int CTRL_TOUCH_IRQ_BIT = 1;
  localparam int CTRL_CONV_IRQ_BIT = 2;
  localparam int STAT_TOUCH_BIT = 0;
  localparam int STAT_CONV_BIT = 1;
  localparam int STAT_TOUCHED_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_POWER_DOWN = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h20;
  localparam logic [1:0] MASK_RESET = 2'h3;
  localparam logic [11:0] ADC_FULL_SCALE = 12'hFFF;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int SETTLE_US = 1000;
  localparam int SETTLE_CYC = (CLK_HZ / 1_000_000) * SETTLE_US;
  localparam int RATE_UNIT_CYC = 1024;
  localparam int SAMPLE_CYC = 64;
  typedef enum logic [2:0] {
    TCS_IDLE = 3'b000,
    TCS_SETTLE = 3'b001,
    TCS_CONV_X = 3'b011,
    TCS_CONV_Y = 3'b010,
    TCS_GAP = 3'b110
  } tcs_state_e;
endpackage

/* File: shared/tcs_adc_if.sv */
// handshake between sequencer and the sample converter
`timescale 1ns/100ps
interface tcs_adc_if;
  logic start;
  logic done;
  logic [11:0] code;
  modport seq (output start, input done, input code);
  modport conv (input start, output done, output code);
endinterface

/* File: verilog/tcs_sample_conv.sv */
// ratiometric 12-bit conversion of one plate sample
`timescale 1ns/100ps
module tcs_sample_conv #(
  parameter int CYC = tcs_pkg::SAMPLE_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [11:0] sense,
  input wire logic [11:0] plate_span,
  tcs_adc_if.conv adc
);
  logic [$clog2(CYC+1)-1:0] cnt_q;
  logic busy_q;
  logic [23:0] prod;
  logic [11:0] ratio;

  // full span maps to 4095; sense is clipped to span first
  always_comb begin
    prod = {12'h000, (sense > plate_span) ? plate_span : sense}
      * 24'(tcs_pkg::ADC_FULL_SCALE);
    ratio = (plate_span == 12'h000) ? 12'h000 :
      12'(prod / {12'h000, plate_span});
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      adc.done <= 1'b0;
      adc.code <= 12'h000;
    end else begin
      adc.done <= 1'b0;
      if (adc.start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= '0;
      end else if (busy_q) begin
        if (cnt_q == ($clog2(CYC+1))'(CYC - 1)) begin
          busy_q <= 1'b0;
          adc.done <= 1'b1;
          adc.code <= ratio;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule // tcs_sample_conv

/* File: sim/tcs_seq_asserts.sv */
// concurrent checks on the sequencer's top-level ports
`timescale 1ns/100ps
module tcs_seq_asserts #(
  parameter int SETTLE_CYC = 50
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic touch_async,
  input wire logic touch_n,
  input wire logic x_plate_high_o,
  input wire logic x_plate_high_oe,
  input wire logic x_plate_low_o,
  input wire logic x_plate_low_oe,
  input wire logic y_plate_high_o,
  input wire logic y_plate_high_oe,
  input wire logic y_plate_low_o,
  input wire logic y_plate_low_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [15:0] since_q;
  // ******************************************
  // cycles since an event raised the interrupt
  // ******************************************
  // a mask write may also raise it; that is no event, so it is skipped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      since_q <= 16'hffff;
    end else if ($rose(irq) && !$past(avs_write, 2)) begin
      since_q <= 16'h0000;
    end else if (since_q != 16'hffff) begin
      since_q <= since_q + 16'h0001;
    end
  end
  a_wait_one_cycle: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("late answer");
  a_wait_low_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_idle_drive: assert property (!x_plate_high_oe && !y_plate_low_oe |->
    y_plate_high_oe && y_plate_high_o && x_plate_low_oe && !x_plate_low_o)
    else $error("idle drive wrong");
  a_x_drive: assert property (x_plate_high_oe |-> x_plate_high_o &&
    x_plate_low_oe && !x_plate_low_o && !y_plate_high_oe && !y_plate_low_oe)
    else $error("x sample drive wrong");
  a_y_drive: assert property (y_plate_low_oe |-> y_plate_high_o &&
    y_plate_high_oe && !y_plate_low_o && !x_plate_high_oe && !x_plate_low_oe)
    else $error("y sample drive wrong");
  a_pair_taken: assert property ($rose(x_plate_high_oe) |=>
    x_plate_high_oe[*8] ##[1:1000] y_plate_low_oe)
    else $error("y sample missing");
  a_irq_cleared: assert property ($fell(irq) |->
    $past(avs_read || avs_write)) else $error("irq dropped alone");
  a_touch_async: assert property (touch_async[*3] |-> !touch_n)
    else $error("touch output not low");
  a_settle_gap: assert property ($rose(x_plate_high_oe) |->
    since_q >= 16'(SETTLE_CYC - 4)) else $error("settle cut");
endmodule // tcs_seq_asserts

bind tcs_sequencer tcs_seq_asserts #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.clk,
  .rstn, .avs_read, .avs_write, .avs_waitrequest, .irq, .touch_async,
  .touch_n, .x_plate_high_o, .x_plate_high_oe, .x_plate_low_o,
  .x_plate_low_oe, .y_plate_high_o, .y_plate_high_oe, .y_plate_low_o,
  .y_plate_low_oe);

/* File: sim/tcs_screen_model.sv */
// behavioural four-wire resistive screen
`timescale 1ns/100ps
module tcs_screen_model (
  input wire logic touched,
  input wire logic [11:0] px,
  input wire logic [11:0] py,
  input wire logic [11:0] span,
  input wire logic y_plate_high_o,
  input wire logic y_plate_high_oe,
  input wire logic x_plate_high_oe,
  input wire logic y_plate_low_oe,
  output logic x_plate_high_i,
  output logic [11:0] y_plate_high_i,
  output logic [11:0] x_plate_sense,
  output logic [11:0] plate_span
);
  assign plate_span = span;
  // contact shorts the driven y plate onto the x plate
  assign x_plate_high_i = touched && y_plate_high_oe && y_plate_high_o;
  // an open sense node shows the inverse, never a stale reading
  assign y_plate_high_i = (touched && x_plate_high_oe) ? px : ~px;
  assign x_plate_sense = (touched && y_plate_low_oe) ? py : ~py;
endmodule // tcs_screen_model

/* File: sim/tb_top.sv */
// self-checking bench for the touch conversion sequencer
`timescale 1ns/100ps
module tb_top;
  localparam int SC = 50;
  localparam int RU = 4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic touch_async = 1'b0;
  logic touched = 1'b0;
  logic xseen = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, x_plate_high_i, x_plate_high_o, x_plate_high_oe;
  logic x_plate_low_o, x_plate_low_oe, y_plate_high_o, y_plate_high_oe;
  logic y_plate_low_o, y_plate_low_oe, touch_n, irq;
  logic [11:0] y_plate_high_i, x_plate_sense, plate_span, px, py, span;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int p1, p2, ex, ey;
  logic [7:0] exp_q[$];

  always #12.5 clk = ~clk;

  tcs_sequencer #(.SETTLE_CYC(SC), .RATE_UNIT_CYC(RU)) uut (.clk, .rstn,
    .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .x_plate_high_i,
    .x_plate_high_o, .x_plate_high_oe, .x_plate_low_o, .x_plate_low_oe,
    .y_plate_high_i, .y_plate_high_o, .y_plate_high_oe, .y_plate_low_o,
    .y_plate_low_oe, .x_plate_sense, .plate_span, .touch_async, .touch_n,
    .irq);

  tcs_screen_model scr (.touched, .px, .py, .span, .y_plate_high_o,
    .y_plate_high_oe, .x_plate_high_oe, .y_plate_low_oe, .x_plate_high_i,
    .y_plate_high_i, .x_plate_sense, .plate_span);

  // ******************************************
  // checking and bus tasks
  // ******************************************
  task automatic complete_run;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // entered just after an edge; releases one edge after the answer
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= 32'(d);
    avs_read <= !w;
    avs_write <= w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  // cycles from one x sample start to the next
  task automatic per(output int p);
    @(posedge clk iff !x_plate_high_oe);
    @(posedge clk iff x_plate_high_oe);
    p = 0;
    while (x_plate_high_oe) begin @(posedge clk); p++; end
    while (!x_plate_high_oe) begin @(posedge clk); p++; end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (x_plate_high_oe === 1'b1) xseen <= 1'b1;
    if (avs_read && avs_waitrequest === 1'b0) begin
      chk(avs_readdata, 32'(exp_q.pop_front()));
    end
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ******************************************
  // main sequence
  // ******************************************
  initial begin
    void'($urandom(32'hd579_a2b2));
    span = 12'h800 | 12'($urandom % 2048);
    px = 12'($urandom % span);
    py = 12'($urandom % span);
    ex = int'(px) * 4095 / int'(span);
    ey = int'(py) * 4095 / int'(span);
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rd(5'(i * 4), i == 7 ? 8'h20 : i == 5 ? 8'h03 : 8'h00);
    end
    touched <= 1'b1;
    repeat (300) @(posedge clk);
    chk(32'(xseen), 32'h0000_0000);
    touched <= 1'b0;
    repeat (4) @(posedge clk);
    rd(tcs_pkg::ADDR_X_LO, 8'h00);
    wr(tcs_pkg::ADDR_CTRL, 8'h07);
    touched <= 1'b1;
    @(posedge clk iff irq);
    rd(tcs_pkg::ADDR_STAT, 8'h81);
    @(posedge clk iff irq);
    rd(tcs_pkg::ADDR_STAT, 8'h82);
    rd(tcs_pkg::ADDR_X_LO, 8'(ex));
    rd(tcs_pkg::ADDR_X_HI, 8'(ex >> 8));
    rd(tcs_pkg::ADDR_Y_LO, 8'(ey));
    rd(tcs_pkg::ADDR_Y_HI, 8'(ey >> 8));
    chk(32'(irq), 32'h0000_0000);
    wr(tcs_pkg::ADDR_MASK, 8'h00);
    @(posedge clk iff y_plate_low_oe);
    @(posedge clk iff !y_plate_low_oe);
    repeat (4) @(posedge clk);
    chk(32'(irq), 32'h0000_0000);
    rd(tcs_pkg::ADDR_STAT, 8'h82);
    wr(tcs_pkg::ADDR_MASK, 8'h03);
    // short rate is held up by the settle floor, long rate is not
    wr(tcs_pkg::ADDR_RATE, 8'h09);
    per(p1);
    per(p1);
    wr(tcs_pkg::ADDR_RATE, 8'h28);
    per(p2);
    per(p2);
    // the settle floor ends one count early: timer reaches SC - 1
    chk(32'(p2 - p1), 32'(40 * RU - (SC - 1)));
    @(posedge clk iff x_plate_high_oe);
    touched <= 1'b0;
    @(posedge clk iff y_plate_low_oe);
    repeat (300) @(posedge clk);
    chk(32'({x_plate_high_oe, irq}), 32'h0000_0001);
    wr(tcs_pkg::ADDR_CTRL, 8'h00);
    wr(tcs_pkg::ADDR_CTRL, 8'h07);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0000_0000);
    rd(tcs_pkg::ADDR_STAT, 8'h00);
    touch_async <= 1'b1;
    repeat (6) @(posedge clk);
    chk(32'(touch_n), 32'h0000_0000);
    chk(32'(irq), 32'h0000_0001);
    complete_run();
  end
endmodule // tb_top
